// ==== bench/io_processor_fault_escalation_bench.sv ====
// Purpose: self-checking bench for the fault unit
// Assumes: 20 MHz clock, host model on apb
// Notes: scenarios run in order, fatal last
`timescale 1ns/1ns
`default_nettype none
module io_processor_fault_escalation_bench;
    logic clock, reset, psel, penable, pwrite, pready, pslverr, sawSend;
    logic [7:0] paddr, funcCode, execStep, faultCode, windowFaultCode;
    logic [31:0] pwdata, prdata, st, rec;
    logic physicalMode, processBound, funcRequest, faultValid, busError, alarm;
    logic [1:0] faultSeverity, functionState;
    logic [4:0] windowFault, windowOpenReq, windowOpen, windowError;
    logic processorFaulted, faultPortSend, attachedHostIrq, fatalOut, subsystemResetRequest;
    int errorCnt, totalChecks;
    iofe_fault_unit iofe_fault_unit_inst (.*);
    iofe_host_model iofe_host_model_inst (.*);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic req(input logic [7:0] fc);
        @(posedge clock);
        funcRequest <= 1'b1;
        funcCode <= fc;
        execStep <= 8'h03;
        @(posedge clock);
        funcRequest <= 1'b0;
    endtask
    // kind 0..2 severity, 3 bus error, 4 alarm
    task automatic hit(input logic [2:0] kind, input logic [7:0] code);
        @(posedge clock);
        faultValid <= (kind < 3'h3);
        faultSeverity <= kind[1:0];
        faultCode <= code;
        busError <= (kind == 3'h3);
        alarm <= (kind == 3'h4);
        @(posedge clock);
        {faultValid, busError, alarm} <= 3'h0;
        faultCode <= ~code;
    endtask
    task automatic waitIrq();
        sawSend = 1'b0;
        for (int n = 0; n < 30 && attachedHostIrq !== 1'b1; n++) begin
            @(negedge clock);
            sawSend |= faultPortSend;
        end
        check("irq", {31'h0, attachedHostIrq}, 32'h1);
    endtask
    task automatic area(input logic [7:0] a, input logic [7:0] code, input logic [7:0] fc);
        iofe_host_model_inst.service(a, st, rec);
        check("record", {8'h0, rec[31:8]}, {8'h0, code, fc + iofe_pkg::OPID_BASE, execStep});
    endtask
    task automatic state(input logic [1:0] exp);
        check("state", {30'h0, functionState}, {30'h0, exp});
    endtask
    // context fault, then two unacknowledged faults escalate
    task automatic escalation();
        processBound <= 1'b1;
        req(8'h05);
        hit(3'h0, 8'h45);
        waitIrq();
        state(iofe_pkg::FS_CONTEXT);
        area(iofe_pkg::OFF_CTXREC, 8'h45, 8'h05);
        hit(3'h0, 8'h46);
        waitIrq();
        state(iofe_pkg::FS_PROCESS);
        check("port send", {31'h0, sawSend}, 32'h1);
        area(iofe_pkg::OFF_PRCREC, 8'h46, 8'h05);
        hit(3'h0, 8'h47);
        waitIrq();
        check("cpu faulted", {31'h0, processorFaulted}, 32'h1);
        area(iofe_pkg::OFF_CPUREC, 8'h47, 8'h05);
        iofe_host_model_inst.ack();
    endtask
    // bad code, unbound process fault, physical mode
    task automatic modes();
        req(8'h20);
        waitIrq();
        state(iofe_pkg::FS_CONTEXT);
        area(iofe_pkg::OFF_CTXREC, iofe_pkg::FC_INVALID, 8'h20);
        iofe_host_model_inst.ack();
        processBound <= 1'b0;
        hit(3'h1, 8'h51);
        waitIrq();
        check("unbound", {31'h0, processorFaulted}, 32'h1);
        area(iofe_pkg::OFF_CPUREC, 8'h51, 8'h20);
        iofe_host_model_inst.ack();
        processBound <= 1'b1;
        physicalMode <= 1'b1;
        // clean request first so the context state must come from this fault
        req(8'h05);
        hit(3'h0, 8'h61);
        waitIrq();
        state(iofe_pkg::FS_CONTEXT);
        area(iofe_pkg::OFF_CPUREC, 8'h61, 8'h05);
        iofe_host_model_inst.ack();
        physicalMode <= 1'b0;
    endtask
    // closed then open window fault, unmapped read
    task automatic windows();
        logic e;
        @(posedge clock);
        windowOpenReq <= 5'h04;
        windowFaultCode <= 8'h77;
        @(posedge clock);
        windowOpenReq <= 5'h00;
        windowFault <= 5'h08;
        @(posedge clock);
        windowFault <= 5'h04;
        @(posedge clock);
        windowFault <= 5'h00;
        waitIrq();
        check("window", {22'h0, windowOpen, windowError}, 32'h4);
        iofe_host_model_inst.service(iofe_pkg::OFF_WINBASE + 8'h08, st, rec);
        check("win record", {24'h0, rec[31:24]}, 32'h77);
        iofe_host_model_inst.xfer(1'b0, 8'h2c, 32'h0, rec, e);
        check("unmapped", {31'h0, e}, 32'h1);
    endtask
    // bus error, then alarm after service but before acknowledge
    task automatic fatal();
        @(posedge clock);
        windowOpenReq <= 5'h11;
        @(posedge clock);
        windowOpenReq <= 5'h00;
        hit(3'h3, 8'h00);
        waitIrq();
        check("bus error", {31'h0, processorFaulted}, 32'h1);
        area(iofe_pkg::OFF_CPUREC, iofe_pkg::FC_BUS_ERROR, 8'h05);
        hit(3'h4, 8'h00);
        for (int n = 0; n < 10 && fatalOut !== 1'b1; n++) begin
            @(negedge clock);
        end
        // windows close one edge after fatal rises
        @(negedge clock);
        check("shutdown", {25'h0, fatalOut, subsystemResetRequest, windowOpen}, 32'h60);
    endtask
    initial begin
        repeat (3000) @(posedge clock);
        errorCnt++;
        summarize();
    end
    initial begin
        reset = 1'b1;
        {physicalMode, processBound, funcRequest, faultValid, busError, alarm} = '0;
        {funcCode, execStep, faultCode, windowFaultCode} = '0;
        {faultSeverity, windowFault, windowOpenReq} = '0;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        escalation();
        modes();
        windows();
        fatal();
        summarize();
    end
endmodule
`default_nettype wire

// ==== bench/iofe_fault_chk.sv ====
// Purpose: assertions on the fault escalation outputs
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the fault unit
`timescale 1ns/1ns
`default_nettype none
module iofe_fault_chk (
    input wire logic clock,
    input wire logic reset,
    input wire logic physicalMode,
    input wire logic processBound,
    input wire logic [4:0] windowFault,
    input wire logic [4:0] windowOpen,
    input wire logic [4:0] windowError,
    input wire logic [1:0] functionState,
    input wire logic processorFaulted,
    input wire logic faultPortSend,
    input wire logic attachedHostIrq,
    input wire logic fatalOut,
    input wire logic subsystemResetRequest
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    // irq only once a fault state shows
    a_irq_after_state: assert property (attachedHostIrq |->
        (functionState != iofe_pkg::FS_SUCCESS || processorFaulted || windowError != 5'h0))
        else $error("irq without fault state");
    a_irq_one_cycle: assert property (attachedHostIrq |=> !attachedHostIrq)
        else $error("irq longer than one cycle");
    a_fatal_sticky: assert property (fatalOut |=> fatalOut && subsystemResetRequest)
        else $error("fatal or reset request dropped");
    a_fatal_closes_all: assert property ($rose(fatalOut) |-> ##[0:2] windowOpen == 5'h0)
        else $error("windows open after fatal");
    a_fatal_second_only: assert property ($rose(fatalOut) |-> $past(processorFaulted))
        else $error("fatal without earlier processor fault");
    a_err_closes_win: assert property (((windowError & ~$past(windowError)) != 5'h0) |->
        (windowOpen & windowError & ~$past(windowError)) == 5'h0)
        else $error("error window left open");
    a_closed_win_quiet: assert property ((windowFault != 5'h0 && (windowFault & windowOpen) == 5'h0) |=>
        windowError == $past(windowError))
        else $error("closed window raised fault");
    a_send_then_irq: assert property (faultPortSend |-> ##[1:6] attachedHostIrq)
        else $error("fault port send without irq");
    a_ctx_bound: assert property (($changed(functionState) && functionState == iofe_pkg::FS_CONTEXT
        && !physicalMode) |-> processBound)
        else $error("context fault while unbound");
    c_irq: cover property (attachedHostIrq);
    c_send: cover property (faultPortSend);
    c_fatal: cover property ($rose(fatalOut));
endmodule
bind iofe_fault_unit iofe_fault_chk iofe_fault_chk_inst (.*);
`default_nettype wire

// ==== bench/iofe_host_model.sv ====
// Purpose: attached host model, apb master and fault service
// Assumes: one clock shared with the fault unit
// Notes: waits on pready, no fixed latency
`timescale 1ns/1ns
`default_nettype none
module iofe_host_model (
    input wire logic clock,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // one transfer, held until pready at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd;
    endtask
    // service: function state first, then the area
    task automatic service(input logic [7:0] area, output logic [31:0] st, output logic [31:0] rec);
        logic e;
        xfer(1'b0, iofe_pkg::OFF_STATUS, 32'h0, st, e);
        xfer(1'b0, area, 32'h0, rec, e);
    endtask
    task automatic ack();
        logic [31:0] r;
        logic e;
        xfer(1'b1, iofe_pkg::OFF_ACK, 32'h1, r, e);
    endtask
endmodule
`default_nettype wire

// ==== core/iofe_fault_unit.sv ====
// Purpose: fault classification, recording and escalation of the I/O interface processor
// Assumes: one 20 MHz clock, synchronous active-high reset, APB slave for records
// Notes: fault areas are held as register records readable over APB
// faults other than window faults that arrive while a record is in flight are not taken
// Function
// - store fault code and operator identifier into the selected fault area
// - operator identifier is function code plus fixed offset, one per code
// - interrupt host for function faults only after record written and function state updated; window faults interrupt in the same cycle as their record
// - record reached execution step for multi-step functions
// - physical mode faults other than bus errors and alarms go to processor area as context-level fault
// - separate context, process areas plus one processor area
// - invalid function code is a context-level fault before execution
// - context fault writes context area, sets state, interrupts host
// - context faults only while a process is bound
// - fault during context handling escalates to process level
// - process fault records, sends to fault port, sets state, interrupts
// - fault during process handling escalates to processor level
// - process-level fault with no bound process becomes processor level
// - bus errors and alarms are processor-level faults
// - first processor fault writes processor area, marks faulted, interrupts
// - second unacknowledged processor fault closes all windows, fatal, reset request
// - one mapping fault area per window 0 to 4, readable by host
// - window fault stores info, closes window, error state, interrupts
// - only open windows raise mapping faults
`timescale 1ns/1ns
`default_nettype none
module iofe_fault_unit (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic physicalMode,
    input wire logic processBound,
    input wire logic funcRequest,
    input wire logic [7:0] funcCode,
    input wire logic [7:0] execStep,
    input wire logic faultValid,
    input wire logic [1:0] faultSeverity,
    input wire logic [7:0] faultCode,
    input wire logic busError,
    input wire logic alarm,
    input wire logic [4:0] windowFault,
    input wire logic [7:0] windowFaultCode,
    input wire logic [4:0] windowOpenReq,
    output logic [4:0] windowOpen,
    output logic [4:0] windowError,
    output logic [1:0] functionState,
    output logic processorFaulted,
    output logic faultPortSend,
    output logic attachedHostIrq,
    output logic fatalOut,
    output logic subsystemResetRequest
);
    // sequencer
    iofe_pkg::iofe_state_t state;
    iofe_pkg::iofe_state_t next_state;

    // fault areas and the record being handled
    iofe_pkg::iofe_record_t ctxRecord;
    iofe_pkg::iofe_record_t prcRecord;
    iofe_pkg::iofe_record_t cpuRecord;
    iofe_pkg::iofe_record_t winRecord [iofe_pkg::NUM_WIN];
    iofe_pkg::iofe_record_t pendRecord;
    logic [1:0] pendLevel;
    logic [1:0] handlingLevel;
    logic handling;

    // classification
    logic [7:0] curOpId;
    logic invalidCode;
    logic anyFault;
    logic takeFault;
    logic [1:0] rawSev;
    logic [1:0] effSev;
    logic [7:0] effCode;
    logic [4:0] liveWinFault;

    // bus side and status
    logic hostAck;
    logic apbWrite;
    logic addrBad;
    logic [31:0] statusWord;
    logic cpuLevelStep;

    // operator identifier derived from function code
    assign curOpId = funcCode + iofe_pkg::OPID_BASE;
    assign invalidCode = funcRequest && (funcCode > iofe_pkg::FUNC_CODE_MAX);
    assign liveWinFault = windowFault & windowOpen;
    assign anyFault = faultValid || busError || alarm || invalidCode;
    assign takeFault = (state == iofe_pkg::ST_IDLE) && anyFault && !fatalOut;
    assign cpuLevelStep = (state == iofe_pkg::ST_UPDATE) && (pendLevel == iofe_pkg::SEV_PROCESSOR);
    assign apbWrite = psel && penable && pwrite;
    assign hostAck = apbWrite && (paddr == iofe_pkg::OFF_ACK) && pwdata[0];

    // raw severity classification
    always_comb begin
        rawSev = faultSeverity;
        if (busError || alarm) begin
            rawSev = iofe_pkg::SEV_PROCESSOR;
        end else if (invalidCode) begin
            rawSev = iofe_pkg::SEV_CONTEXT;
        end
    end

    // fault code recorded for the incoming fault
    always_comb begin
        effCode = faultCode;
        if (busError) begin
            effCode = iofe_pkg::FC_BUS_ERROR;
        end else if (alarm) begin
            effCode = iofe_pkg::FC_ALARM;
        end else if (invalidCode) begin
            effCode = iofe_pkg::FC_INVALID;
        end
    end

    // escalation against current handling and binding
    always_comb begin
        effSev = rawSev;
        if (handling && handlingLevel == iofe_pkg::SEV_CONTEXT && rawSev == iofe_pkg::SEV_CONTEXT) begin
            effSev = iofe_pkg::SEV_PROCESS;
        end else if (handling && handlingLevel != iofe_pkg::SEV_CONTEXT) begin
            effSev = iofe_pkg::SEV_PROCESSOR;
        end
        if (effSev == iofe_pkg::SEV_CONTEXT && !processBound) begin
            effSev = iofe_pkg::SEV_PROCESS;
        end
        if (effSev == iofe_pkg::SEV_PROCESS && !processBound) begin
            effSev = iofe_pkg::SEV_PROCESSOR;
        end
        if (physicalMode && !(busError || alarm)) begin
            effSev = iofe_pkg::SEV_CONTEXT;
        end
    end

    // sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            iofe_pkg::ST_IDLE: begin
                if (takeFault) begin
                    next_state = iofe_pkg::ST_WRITE;
                end
            end
            iofe_pkg::ST_WRITE: begin
                next_state = iofe_pkg::ST_UPDATE;
            end
            iofe_pkg::ST_UPDATE: begin
                next_state = iofe_pkg::ST_IRQ;
            end
            iofe_pkg::ST_IRQ: begin
                next_state = iofe_pkg::ST_IDLE;
            end
            default: begin
                next_state = iofe_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= iofe_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // capture the fault being handled
    always_ff @(posedge clock) begin
        if (reset) begin
            pendRecord <= '0;
            pendLevel <= iofe_pkg::SEV_CONTEXT;
        end else if (takeFault) begin
            pendRecord.faultCode <= effCode;
            pendRecord.operatorId <= curOpId;
            pendRecord.execStep <= execStep;
            pendRecord.spare <= '0;
            pendLevel <= effSev;
        end
    end

    // handling flag, held until the host acknowledges; set wins
    always_ff @(posedge clock) begin
        if (reset) begin
            handling <= 1'b0;
            handlingLevel <= iofe_pkg::SEV_CONTEXT;
        end else if (state == iofe_pkg::ST_WRITE) begin
            handling <= 1'b1;
            handlingLevel <= pendLevel;
        end else if (hostAck) begin
            handling <= 1'b0;
        end
    end

    // write the selected fault area
    always_ff @(posedge clock) begin
        if (reset) begin
            ctxRecord <= '0;
            prcRecord <= '0;
            cpuRecord <= '0;
        end else if (state == iofe_pkg::ST_WRITE) begin
            if (physicalMode && pendLevel == iofe_pkg::SEV_CONTEXT) begin
                cpuRecord <= pendRecord;
            end else if (pendLevel == iofe_pkg::SEV_CONTEXT) begin
                ctxRecord <= pendRecord;
            end else if (pendLevel == iofe_pkg::SEV_PROCESS) begin
                prcRecord <= pendRecord;
            end else if (!processorFaulted) begin
                cpuRecord <= pendRecord;
            end
        end
    end

    // function state: success on a clean request, context or process level after update; processor-level faults leave it unchanged
    always_ff @(posedge clock) begin
        if (reset) begin
            functionState <= iofe_pkg::FS_SUCCESS;
        end else if (state == iofe_pkg::ST_UPDATE) begin
            if (pendLevel == iofe_pkg::SEV_CONTEXT) begin
                functionState <= iofe_pkg::FS_CONTEXT;
            end else if (pendLevel == iofe_pkg::SEV_PROCESS) begin
                functionState <= iofe_pkg::FS_PROCESS;
            end
        end else if (funcRequest && state == iofe_pkg::ST_IDLE && !anyFault) begin
            functionState <= iofe_pkg::FS_SUCCESS;
        end
    end

    // processor status; set wins over host acknowledge
    always_ff @(posedge clock) begin
        if (reset) begin
            processorFaulted <= 1'b0;
        end else if (cpuLevelStep) begin
            processorFaulted <= 1'b1;
        end else if (hostAck) begin
            processorFaulted <= 1'b0;
        end
    end

    // second processor fault before acknowledge: sticky shutdown until reset
    always_ff @(posedge clock) begin
        if (reset) begin
            fatalOut <= 1'b0;
            subsystemResetRequest <= 1'b0;
        end else if (cpuLevelStep && processorFaulted) begin
            fatalOut <= 1'b1;
            subsystemResetRequest <= 1'b1;
        end
    end

    // fault port send, on the same edge as a process-level record write
    always_ff @(posedge clock) begin
        if (reset) begin
            faultPortSend <= 1'b0;
        end else begin
            faultPortSend <= (state == iofe_pkg::ST_WRITE) && (pendLevel == iofe_pkg::SEV_PROCESS)
                && !physicalMode;
        end
    end

    // host interrupt pulse, only once record and state stand
    always_ff @(posedge clock) begin
        if (reset) begin
            attachedHostIrq <= 1'b0;
        end else begin
            attachedHostIrq <= (state == iofe_pkg::ST_IRQ && !fatalOut) || (|liveWinFault);
        end
    end

    // window mapping faults, one area per window
    genvar w;
    generate
        for (w = 0; w < iofe_pkg::NUM_WIN; w++) begin : gWin
            // per-window fault record
            always_ff @(posedge clock) begin
                if (reset) begin
                    winRecord[w] <= '0;
                end else if (liveWinFault[w] && !fatalOut) begin
                    winRecord[w].faultCode <= windowFaultCode;
                    winRecord[w].operatorId <= curOpId;
                    winRecord[w].execStep <= execStep;
                    winRecord[w].spare <= '0;
                end
            end
            // per-window open and error state
            always_ff @(posedge clock) begin
                if (reset) begin
                    windowOpen[w] <= 1'b0;
                    windowError[w] <= 1'b0;
                end else if (fatalOut) begin
                    windowOpen[w] <= 1'b0;
                end else if (liveWinFault[w]) begin
                    windowOpen[w] <= 1'b0;
                    windowError[w] <= 1'b1;
                end else if (windowOpenReq[w]) begin
                    windowOpen[w] <= 1'b1;
                    windowError[w] <= 1'b0;
                end
            end
        end
    endgenerate

    // status word: fault flags above the function state
    assign statusWord = {22'h0, subsystemResetRequest, fatalOut, processorFaulted, windowError, functionState};

    // apb read data
    always_ff @(posedge clock) begin
        if (reset) begin
            prdata <= iofe_pkg::RESET_WORD;
        end else if (psel && !penable && !pwrite) begin
            prdata <= iofe_pkg::RESET_WORD;
            if (paddr == iofe_pkg::OFF_STATUS) begin
                prdata <= statusWord;
            end else if (paddr == iofe_pkg::OFF_CTXREC) begin
                prdata <= ctxRecord;
            end else if (paddr == iofe_pkg::OFF_PRCREC) begin
                prdata <= prcRecord;
            end else if (paddr == iofe_pkg::OFF_CPUREC) begin
                prdata <= cpuRecord;
            end else if (paddr == iofe_pkg::OFF_CTRL) begin
                prdata <= {27'h0, windowOpen};
            end else begin
                for (int i = 0; i < iofe_pkg::NUM_WIN; i++) begin
                    if (paddr == iofe_pkg::OFF_WINBASE + 8'(4 * i)) begin
                        prdata <= winRecord[i];
                    end
                end
            end
        end
    end

    // no wait state: read data registered in setup, answered in access
    assign addrBad = (paddr[1:0] != 2'h0) || (paddr > iofe_pkg::OFF_ACK);
    assign pready = 1'b1;
    assign pslverr = psel && penable && addrBad;
endmodule
`default_nettype wire

// ==== include/iofe_pkg.sv ====
// Purpose: shared constants and types for the fault escalation block
// Assumes: APB register access, 32-bit data
// Notes: offsets are byte addresses
`default_nettype none
package iofe_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CTXREC = 8'h08;
    localparam logic [7:0] OFF_PRCREC = 8'h0c;
    localparam logic [7:0] OFF_CPUREC = 8'h10;
    localparam logic [7:0] OFF_WINBASE = 8'h14;
    localparam logic [7:0] OFF_ACK = 8'h28;
    localparam int NUM_WIN = 5;
    // function state encoding
    localparam logic [1:0] FS_SUCCESS = 2'h0;
    localparam logic [1:0] FS_CONTEXT = 2'h1;
    localparam logic [1:0] FS_PROCESS = 2'h2;
    localparam logic [1:0] FS_BUSY = 2'h3;
    // severity of an incoming fault
    localparam logic [1:0] SEV_CONTEXT = 2'h0;
    localparam logic [1:0] SEV_PROCESS = 2'h1;
    localparam logic [1:0] SEV_PROCESSOR = 2'h2;
    // operator identifier offset from function code
    localparam logic [7:0] OPID_BASE = 8'h80;
    localparam logic [7:0] FUNC_CODE_MAX = 8'h1f;
    localparam logic [7:0] FC_INVALID = 8'h01;
    localparam logic [7:0] FC_BUS_ERROR = 8'h02;
    localparam logic [7:0] FC_ALARM = 8'h03;
    localparam logic [31:0] RESET_WORD = 32'h00000000;

    typedef struct packed {
        logic [7:0] faultCode;
        logic [7:0] operatorId;
        logic [7:0] execStep;
        logic [7:0] spare;
    } iofe_record_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_UPDATE = 4'b0100,
        ST_IRQ = 4'b1000
    } iofe_state_t;
endpackage
`default_nettype wire
